// ==== logic/rts_regs.svh ====
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define RTS_OFF_POWER_CONTROL_REGISTER  2'h0
`define RTS_OFF_STS   2'h1
`define RTS_OFF_MSK   2'h2
`define RTS_POWER_CONTROL_REGISTER_BOR  0
`define RTS_POWER_CONTROL_REGISTER_POR  1
`define RTS_POWER_CONTROL_REGISTER_W    2
`define RTS_EV_W      5
`define RTS_POWER_CONTROL_REGISTER_RST  2'h0
`define RTS_STS_RST   5'h00
`define RTS_MSK_RST   5'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTS_PUD_MS    64
`define RTS_LFO_HZ    31000
`define RTS_PUD_TICKS ((`RTS_PUD_MS * `RTS_LFO_HZ) / 1000)
`define RTS_OST_TICKS 1024
`define RTS_CNT_W     12

`endif

// ==== logic/rts_pkg.sv ====
package rts_pkg;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		low_power_crystal_mode,
		crystal_mode,
		high_speed_crystal_mode,
		resistor_capacitor_mode,
		external_clock_mode,
		internal_oscillator_mode
	} rts_osc_t;

	typedef enum logic [2:0] {
		ST_HOLD, ST_PUD, ST_OSU, ST_PIN, ST_RUN, ST_SLEEP
	} rts_state_t;

	typedef enum logic [1:0] {
		CLS_NONE, CLS_POWER, CLS_PIN_WDOG, CLS_WAKE
	} rts_class_t;

	typedef struct packed {
		rts_osc_t   osc;
		logic       power_up_timer_disable;
		logic [1:0] brown_out_enable_field;
	} rts_cfg_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rts_bus_t;

	typedef struct packed {
		logic por;
		logic bor;
		logic pin;
		logic wdt;
		logic wake;
	} rts_evt_t;

endpackage : rts_pkg

// ==== logic/rts_seq.sv ====
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "rts_regs.svh"
// Operation
// [R1] delay after power-on pulse, then start-up count
// [R2] external clock, timer disabled: no time-out
// [R3] time-outs ignore pin; release on pin high
// [R4] crystal modes add 1024 periods; others delay only
// [R5] brown-out clears bit 0; others leave it
// [R6] brown-out flag don't-care when field 00
// [R7] bit 1 zero on power-on; software sets
// [R8] three init classes; wake keeps registers
// [R9] unimplemented bits read zero
// [R10] supply collapse escalates to power-on reset
// [R11] 64 ms delay on low-power ticks, holding reset
// [R12] brown-out during delay restarts full delay
// [R13] watchdog held during start-up count
// [R14] cause flags hold until write or event
module rts_seq (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire rts_pkg::rts_cfg_t cfg,
	input  wire logic              por_pulse,
	input  wire logic              bor_det,
	input  wire logic              external_reset_pin,
	input  wire logic              wdt_timeout,
	input  wire logic              sleep_req,
	input  wire logic              wake_evt,
	input  wire logic              lfo_tick,
	input  wire logic              osc_tick,
	input  wire rts_pkg::rts_bus_t bus,
	output logic [7:0]             rd_data,
	output logic                   core_reset,
	output logic                   core_run,
	output logic                   watchdog_hold,
	output rts_pkg::rts_class_t    init_class,
	output logic                   init_strobe,
	output logic                   irq
);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	rts_pkg::rts_state_t     state_q, state_d;
	rts_pkg::rts_class_t     cls_q, cls_d;
	logic [`RTS_CNT_W-1:0]   cnt_q, cnt_d;
	logic                    stb_q, stb_d;
	logic                    por_q, bor_q;
	rts_pkg::rts_evt_t       ev;
	logic                    crystal;
	logic                    bor_act;
	logic                    pud_done;
	logic                    osu_done;

	assign crystal = (cfg.osc == rts_pkg::low_power_crystal_mode) ||
		(cfg.osc == rts_pkg::crystal_mode) ||
		(cfg.osc == rts_pkg::high_speed_crystal_mode);
	// disabled field never trips, so the flag is left alone
	assign bor_act = bor_det && (cfg.brown_out_enable_field == 2'h3 || // R6
		(cfg.brown_out_enable_field == 2'h2 && state_q != rts_pkg::ST_SLEEP));
	assign pud_done = lfo_tick &&
		(cnt_q == `RTS_CNT_W'(`RTS_PUD_TICKS - 1)); // R11
	assign osu_done = osc_tick &&
		(cnt_q == `RTS_CNT_W'(`RTS_OST_TICKS - 1)); // R4

	always_comb begin
		state_d = state_q;
		cls_d   = cls_q;
		cnt_d   = cnt_q;
		stb_d   = 1'b0;
		ev      = '0;
		unique case (state_q)
			rts_pkg::ST_HOLD: begin
				cnt_d = '0;
				if (!cfg.power_up_timer_disable)
					state_d = rts_pkg::ST_PUD; // R1
				else if (crystal)
					state_d = rts_pkg::ST_OSU; // R4
				else
					state_d = rts_pkg::ST_PIN; // R2
			end
			rts_pkg::ST_PUD: begin
				if (pud_done) begin
					cnt_d   = '0;
					state_d = crystal ? rts_pkg::ST_OSU : rts_pkg::ST_PIN; // R1
				end else if (lfo_tick) begin
					cnt_d = cnt_q + 1'b1; // R11
				end
			end
			rts_pkg::ST_OSU: begin
				if (osu_done) begin
					cnt_d   = '0;
					state_d = (cls_q == rts_pkg::CLS_WAKE) ?
						rts_pkg::ST_RUN : rts_pkg::ST_PIN; // R13
				end else if (osc_tick) begin
					cnt_d = cnt_q + 1'b1; // R4
				end
			end
			rts_pkg::ST_PIN: begin
				if (external_reset_pin)
					state_d = rts_pkg::ST_RUN; // R3
			end
			rts_pkg::ST_RUN: begin
				if (!external_reset_pin) begin
					state_d = rts_pkg::ST_PIN;
					cls_d   = rts_pkg::CLS_PIN_WDOG; // R8
					ev.pin  = 1'b1;
					stb_d   = 1'b1;
				end else if (wdt_timeout) begin
					state_d = rts_pkg::ST_PIN;
					cls_d   = rts_pkg::CLS_PIN_WDOG; // R8
					ev.wdt  = 1'b1;
					stb_d   = 1'b1;
				end else if (sleep_req) begin
					state_d = rts_pkg::ST_SLEEP;
				end
			end
			rts_pkg::ST_SLEEP: begin
				if (!external_reset_pin) begin
					state_d = rts_pkg::ST_PIN;
					cls_d   = rts_pkg::CLS_PIN_WDOG; // R8
					ev.pin  = 1'b1;
					stb_d   = 1'b1;
				end else if (wake_evt || wdt_timeout) begin
					cnt_d   = '0;
					state_d = crystal ? rts_pkg::ST_OSU : rts_pkg::ST_RUN; // R4
					cls_d   = rts_pkg::CLS_WAKE; // R8
					ev.wake = 1'b1;
					stb_d   = 1'b1;
				end
			end
		endcase
		if (bor_act && !por_pulse) begin
			state_d = rts_pkg::ST_HOLD; // R12
			cnt_d   = '0;
			cls_d   = rts_pkg::CLS_POWER;
			ev      = '0;
			ev.bor  = !bor_q;
			stb_d   = !bor_q;
		end
		if (por_pulse) begin
			state_d = rts_pkg::ST_HOLD; // R10
			cnt_d   = '0;
			cls_d   = rts_pkg::CLS_POWER;
			ev      = '0;
			ev.por  = !por_q;
			stb_d   = !por_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= rts_pkg::ST_HOLD;
			cls_q   <= rts_pkg::CLS_POWER;
			cnt_q   <= '0;
			stb_q   <= 1'b0;
			por_q   <= 1'b0;
			bor_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cls_q   <= cls_d;
			cnt_q   <= cnt_d;
			stb_q   <= stb_d;
			por_q   <= por_pulse;
			bor_q   <= bor_act;
		end
	end

	assign core_run      = (state_q == rts_pkg::ST_RUN);
	assign core_reset    = !core_run && (state_q != rts_pkg::ST_SLEEP) &&
		(cls_q != rts_pkg::CLS_WAKE);
	assign watchdog_hold = (state_q == rts_pkg::ST_OSU); // R13
	assign init_class    = cls_q;
	assign init_strobe   = stb_q;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [`RTS_POWER_CONTROL_REGISTER_W-1:0] power_control_register_q, power_control_register_d;
	logic [`RTS_EV_W-1:0]   sts_q, sts_d;
	logic [`RTS_EV_W-1:0]   msk_q, msk_d;
	logic [7:0]             rdat_q, rdat_d;
	logic                   wr_power_control_register, wr_sts, wr_msk;

	assign wr_power_control_register = bus.wr && (bus.addr == `RTS_OFF_POWER_CONTROL_REGISTER);
	assign wr_sts  = bus.wr && (bus.addr == `RTS_OFF_STS);
	assign wr_msk  = bus.wr && (bus.addr == `RTS_OFF_MSK);

	always_comb begin
		power_control_register_d = power_control_register_q;
		if (wr_power_control_register)
			power_control_register_d = bus.wdata[`RTS_POWER_CONTROL_REGISTER_W-1:0]; // R14
		if (por_pulse)
			power_control_register_d[`RTS_POWER_CONTROL_REGISTER_POR] = 1'b0; // R7
		if (ev.bor)
			power_control_register_d[`RTS_POWER_CONTROL_REGISTER_BOR] = 1'b0; // R5
		sts_d = sts_q;
		if (wr_sts)
			sts_d = sts_q & ~bus.wdata[`RTS_EV_W-1:0];
		sts_d = sts_d | ev;
		msk_d = wr_msk ? bus.wdata[`RTS_EV_W-1:0] : msk_q;
		rdat_d = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				`RTS_OFF_POWER_CONTROL_REGISTER: rdat_d = {6'h00, power_control_register_q}; // R9
				`RTS_OFF_STS:  rdat_d = {3'h0, sts_q};   // R9
				`RTS_OFF_MSK:  rdat_d = {3'h0, msk_q};
				default:       rdat_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_control_register_q <= `RTS_POWER_CONTROL_REGISTER_RST;
			sts_q  <= `RTS_STS_RST;
			msk_q  <= `RTS_MSK_RST;
			rdat_q <= 8'h00;
		end else begin
			power_control_register_q <= power_control_register_d;
			sts_q  <= sts_d;
			msk_q  <= msk_d;
			rdat_q <= rdat_d;
		end
	end

	assign rd_data = rdat_q;
	assign irq     = |(sts_q & msk_q);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_quiet;
		!por_pulse && !bor_act;
	endsequence

	sequence s_bor_in_pud;
		state_q == rts_pkg::ST_PUD && bor_act && !por_pulse;
	endsequence

	pud_start_a: assert property ( // R1
		(state_q == rts_pkg::ST_HOLD && !cfg.power_up_timer_disable) and s_quiet
		|=> state_q == rts_pkg::ST_PUD && cnt_q == '0)
		else $error("delay did not start after reset pulse");

	osu_order_a: assert property ( // R1
		$rose(state_q == rts_pkg::ST_OSU) && cls_q == rts_pkg::CLS_POWER
		|-> $past(state_q) == rts_pkg::ST_PUD || cfg.power_up_timer_disable)
		else $error("start-up count began before delay");

	no_timeout_a: assert property ( // R2
		(state_q == rts_pkg::ST_HOLD && cfg.power_up_timer_disable &&
		cfg.osc == rts_pkg::external_clock_mode) and s_quiet
		|=> state_q == rts_pkg::ST_PIN ##0 external_reset_pin [*1]
		|=> core_run)
		else $error("time-out applied with timer disabled");

	pin_release_a: assert property ( // R3
		(state_q == rts_pkg::ST_PIN && external_reset_pin) and s_quiet
		|=> core_run && !core_reset)
		else $error("pin release did not start execution");

	ost_len_a: assert property ( // R4
		(state_q == rts_pkg::ST_OSU && osu_done) and s_quiet
		|=> state_q != rts_pkg::ST_OSU && !watchdog_hold) // R13
		else $error("start-up count length wrong");

	pud_len_a: assert property ( // R11
		state_q == rts_pkg::ST_PUD |-> cnt_q < `RTS_CNT_W'(`RTS_PUD_TICKS)
		&& core_reset)
		else $error("delay count overran or reset released");

	bor_flag_a: assert property ( // R5
		$rose(bor_act) && !por_pulse |=> !power_control_register_q[`RTS_POWER_CONTROL_REGISTER_BOR])
		else $error("brown-out did not clear flag");

	por_flag_a: assert property ( // R7
		por_pulse |=> !power_control_register_q[`RTS_POWER_CONTROL_REGISTER_POR] && cls_q == rts_pkg::CLS_POWER) // R10
		else $error("power-on did not clear flag");

	wake_keep_a: assert property ( // R8
		ev.wake && !wr_power_control_register |=> $stable(power_control_register_q) && init_class == rts_pkg::CLS_WAKE)
		else $error("wake altered cause flags");

	unimpl_zero_a: assert property ( // R9
		bus.rd && bus.addr == `RTS_OFF_POWER_CONTROL_REGISTER |=> rd_data[7:2] == 6'h00)
		else $error("unimplemented bits not zero");

	bor_restart_a: assert property ( // R12
		s_bor_in_pud |=> state_q == rts_pkg::ST_HOLD ##0 cnt_q == '0)
		else $error("brown-out did not restart delay");

	sticky_a: assert property ( // R14
		!wr_power_control_register && !por_pulse && !(bor_act && !bor_q) |=> $stable(power_control_register_q))
		else $error("cause flags changed without cause");

endmodule : rts_seq

// ==== verification/tb.sv ====
`timescale 1ns/1ns
`include "rts_regs.svh"
module tb;
	localparam int D = `RTS_PUD_TICKS;
	localparam int O = `RTS_OST_TICKS;
	logic                clk, rst_n, por_pulse, bor_det, pin, wdt_timeout, sleep_req, wake_evt;
	logic                tick, tick_half;
	rts_pkg::rts_cfg_t   cfg;
	rts_pkg::rts_bus_t   bus;
	logic [7:0]          rd_data;
	logic                core_reset, core_run, watchdog_hold, init_strobe, irq;
	rts_pkg::rts_class_t init_class;
	int                  num_errors, cmp_count, n, hcnt;

	rts_seq u_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .por_pulse(por_pulse),
		.bor_det(bor_det), .external_reset_pin(pin), .wdt_timeout(wdt_timeout),
		.sleep_req(sleep_req), .wake_evt(wake_evt), .lfo_tick(tick), .osc_tick(tick),
		.bus(bus), .rd_data(rd_data), .core_reset(core_reset), .core_run(core_run),
		.watchdog_hold(watchdog_hold), .init_class(init_class),
		.init_strobe(init_strobe), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) tick <= !tick_half || !tick;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wrap_up;
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(rd_data & m, exp);
	endtask : rdc

	// 0 power-on, 1 brown-out, 2 pin, 3 watchdog, 4 sleep, 5 wake
	task automatic set(input int k, input logic v);
		case (k)
			0: por_pulse <= v;
			1: bor_det <= v;
			2: pin <= ~v;
			3: wdt_timeout <= v;
			4: sleep_req <= v;
			default: wake_evt <= v;
		endcase
	endtask : set

	task automatic pulse(input int k, input int len);
		@(posedge clk);
		set(k, 1'b1);
		repeat (len) @(posedge clk);
		set(k, 1'b0);
	endtask : pulse

	task automatic setcfg(input rts_pkg::rts_osc_t o, input logic dis, input logic [1:0] f);
		@(posedge clk);
		cfg <= '{o, dis, f};
	endtask : setcfg

	task automatic wait_run(input int lim);
		n = 0;
		hcnt = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (watchdog_hold === 1'b1) hcnt++;
			if (n > lim) begin
				num_errors++;
				wrap_up();
			end
		end while (core_run !== 1'b1);
	endtask : wait_run

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_modes;
		int e;
		int h;
		for (int i = 0; i < 12; i++) begin
			h = ((i / 2) < 3) ? O : 0;
			e = (i[0] ? 0 : D) + h;
			setcfg(rts_pkg::rts_osc_t'(i / 2), i[0], 2'b11);
			pulse(0, 2);
			wait_run(4000);
			chk(n >= e && n <= e + 6, 1);
			chk(hcnt >= h && hcnt <= h + 2 * (h > 0), 1);
			chk(core_reset, 0);
			chk(init_class, rts_pkg::CLS_POWER);
			rdc(0, 8'h00, 8'h02);
		end
	endtask : t_modes

	task automatic t_pin;
		setcfg(rts_pkg::crystal_mode, 1'b0, 2'b11);
		pin <= 1'b0;
		pulse(0, 2);
		repeat (D + O + 20) @(posedge clk);
		#1 chk(core_run, 0);
		chk(core_reset, 1);
		@(posedge clk);
		pin <= 1'b1;
		wait_run(3);
		chk(n <= 2, 1);
	endtask : t_pin

	task automatic t_flags;
		wr(0, 8'h03);
		rdc(0, 8'h03, 8'hFF);
		pulse(2, 2);
		wait_run(10);
		chk(init_class, rts_pkg::CLS_PIN_WDOG);
		rdc(0, 8'h03, 8'hFF);
		pulse(3, 1);
		#1 chk(init_strobe, 1);
		wait_run(10);
		chk(init_strobe, 0);
		chk(init_class, rts_pkg::CLS_PIN_WDOG);
		rdc(0, 8'h03, 8'hFF);
		pulse(1, 2);
		wait_run(4000);
		chk(init_class, rts_pkg::CLS_POWER);
		rdc(0, 8'h02, 8'hFF);
		rdc(3, 8'h00, 8'hFF);
		wr(3, 8'hFF);
		rdc(0, 8'h02, 8'hFF);
		setcfg(rts_pkg::crystal_mode, 1'b0, 2'b00);
		pulse(1, 3);
		#1 chk(core_run, 1);
		setcfg(rts_pkg::crystal_mode, 1'b0, 2'b11);
		wr(0, 8'h03);
		pin <= 1'b0;
		pulse(0, 2);
		@(posedge clk);
		pin <= 1'b1;
		wait_run(4000);
		rdc(0, 8'h00, 8'h02);
	endtask : t_flags

	task automatic t_irq;
		wr(1, 8'h1F);
		wr(2, 8'h08);
		rdc(1, 8'h00, 8'hFF);
		pulse(2, 2);
		wait_run(10);
		chk(irq, 0);
		pulse(1, 2);
		wait_run(4000);
		chk(irq, 1);
		rdc(1, 8'h0C, 8'h0C);
		wr(1, 8'h08);
		#1 chk(irq, 0);
		rdc(1, 8'h04, 8'h0C);
	endtask : t_irq

	task automatic t_sleep;
		wr(0, 8'h03);
		pulse(4, 1);
		#1 chk(core_run, 0);
		pulse(5, 1);
		wait_run(O + 10);
		chk(n >= O && n <= O + 6, 1);
		chk(hcnt >= O - 1 && hcnt <= O + 1, 1);
		chk(init_class, rts_pkg::CLS_WAKE);
		rdc(0, 8'h03, 8'hFF);
		setcfg(rts_pkg::resistor_capacitor_mode, 1'b0, 2'b10);
		pulse(4, 1);
		pulse(1, 2);
		pulse(3, 1);
		wait_run(10);
		chk(hcnt, 0);
		chk(init_class, rts_pkg::CLS_WAKE);
	endtask : t_sleep

	task automatic t_restart;
		setcfg(rts_pkg::crystal_mode, 1'b0, 2'b11);
		tick_half <= 1'b1;
		pulse(0, 2);
		repeat (1000) @(posedge clk);
		pulse(1, 2);
		wait_run(7000);
		chk(n >= 2 * (D + O) && n <= 2 * (D + O) + 6, 1);
	endtask : t_restart

	initial begin
		rst_n = 1'b0;
		{por_pulse, bor_det, wdt_timeout, sleep_req, wake_evt} = '0;
		pin = 1'b1;
		bus = '0;
		tick_half = 1'b0;
		cfg = '{rts_pkg::external_clock_mode, 1'b1, 2'b11};
		num_errors = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_modes();
		t_pin();
		t_flags();
		t_irq();
		t_sleep();
		t_restart();
		wrap_up();
	end
endmodule : tb
